// ==== rtl/dtc_timer.sv ====
// dual 16-bit timer/counter with external interrupt edge flags, wishbone slave
// assumes pins are asynchronous to clk_i and service strobes are on clk_i
`timescale 1ns/1ns
`default_nettype none

module dtc_timer
   import dtc_pkg::*;
#(
   parameter int unsigned MACHINE_DIV = CLKS_PER_MACHINE
) (
   input  wire logic             clk_i,         // processor clock
   input  wire logic             rst_i,         // synchronous reset, active high
   input  wire logic             wb_cyc_i,      // bus cycle
   input  wire logic             wb_stb_i,      // strobe
   input  wire logic             wb_we_i,       // write enable
   input  wire logic [ADR_W+1:0] wb_adr_i,      // byte address
   input  wire logic [3:0]       wb_sel_i,      // byte lanes
   input  wire logic [31:0]      wb_dat_i,      // write data
   output logic      [31:0]      wb_dat_o,      // read data
   output logic                  wb_ack_o,      // acknowledge
   input  wire logic [1:0]       count_input_i, // external count inputs
   input  wire logic [1:0]       ext_pin_i,     // external interrupt / gate pins
   input  wire logic [1:0]       ovf_served_i,  // overflow interrupt serviced
   input  wire logic [1:0]       ext_served_i,  // pin interrupt serviced
   output logic      [1:0]       ovf_flag_o,    // overflow flags
   output logic      [1:0]       ext_req_o      // pin interrupt requests
);

   // ----------------------------------------------------------------
   // counting step shared by every byte pair
   // ----------------------------------------------------------------
   function automatic dtc_step_t step(input logic [7:0] lo,
                                      input logic [7:0] hi,
                                      input dtc_mode_t  m,
                                      input logic       inc);
      dtc_step_t r;
      r.ovf = 1'b0;
      r.hi  = hi;
      r.lo  = lo;
      unique case (m)
         DTC_MODE_13: begin
            if (inc) begin
               if (lo[4:0] == 5'h1F) begin
                  {r.ovf, r.hi} = {1'b0, hi} + 9'h001;
                  r.lo          = 8'h00;
               end else begin
                  r.lo = {3'h0, lo[4:0] + 5'h01};
               end
            end
            r.lo[7:5] = 3'h0;
         end
         DTC_MODE_16: begin
            if (inc) begin
               {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h00001;
            end
         end
         DTC_MODE_RELOAD: begin
            if (inc) begin
               if (lo == 8'hFF) begin
                  r.lo  = hi;
                  r.ovf = 1'b1;
               end else begin
                  r.lo = lo + 8'h01;
               end
            end
         end
         DTC_MODE_SPLIT: begin
            if (inc) begin
               {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
            end
         end
      endcase
      return r;
   endfunction

   // only the 13- and 16-bit modes carry a step into the high byte; in the other modes a
   // software write to it must not be lost to a low byte step in that cycle
   function automatic logic moves_high(input dtc_mode_t m);
      return (m == DTC_MODE_13) || (m == DTC_MODE_16);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  control;
   logic [7:0]  mode_sel;
   logic [7:0]  cnt_lo [2];
   logic [7:0]  cnt_hi [2];
   logic [3:0]  pre;
   logic [1:0]  cnt_meta;
   logic [1:0]  cnt_sync;
   logic [1:0]  cnt_smp;
   logic [1:0]  pin_meta;
   logic [1:0]  pin_sync;
   logic [1:0]  pin_prev;

   logic [7:0]  next_control;
   logic [7:0]  next_mode_sel;
   logic [7:0]  next_lo [2];
   logic [7:0]  next_hi [2];
   logic [3:0]  next_pre;
   logic [1:0]  next_cnt_smp;
   logic [31:0] next_dat;
   logic        next_ack;
   logic [1:0]  next_ext_req;

   dtc_unit_cfg_t cfg [2];
   logic          tick;
   logic [1:0]    cnt_fall;
   logic [1:0]    pin_fall;
   logic [1:0]    run;
   logic [1:0]    unit_inc;
   logic          hi0_inc;
   dtc_step_t     res [2];
   dtc_step_t     res_hi0;
   logic          req;
   logic          wr;
   logic [5:0]    idx;

   assign cfg[0] = dtc_unit_cfg_t'(mode_sel[MODE_NIB_ZERO +: 4]);
   assign cfg[1] = dtc_unit_cfg_t'(mode_sel[MODE_NIB_ONE +: 4]);
   assign run    = {control[B_RUN_ONE], control[B_RUN_ZERO]};
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = req & wb_we_i & wb_sel_i[0];
   assign idx    = wb_adr_i[ADR_W+1:2];

   // ----------------------------------------------------------------
   // machine cycle prescaler and edge detection
   // ----------------------------------------------------------------
   // the prescaler free-runs from reset, so the first step after a run bit
   // is set comes 1 to MACHINE_DIV clocks later; a run window is exact only
   // in whole machine cycles
   assign tick = (pre == 4'(MACHINE_DIV - 1));

   // count inputs are sampled once per machine cycle: a fall needs a high sample
   // then a low sample, so the source must hold each level a machine cycle
   assign cnt_fall = tick ? (cnt_smp & ~cnt_sync) : 2'b00;
   assign pin_fall = pin_prev & ~pin_sync;

   generate
      for (genvar u = 0; u < 2; u++) begin : g_unit
         // unit 1 in mode 3 halts; unit 0 mode 3 high byte borrows run 1
         assign unit_inc[u] = run[u]
                            & (~cfg[u].gate | pin_sync[u])
                            & (cfg[u].ctr ? cnt_fall[u] : tick)
                            & ~(u == 1 && cfg[u].mode == DTC_MODE_SPLIT);
         assign res[u] = step(cnt_lo[u], cnt_hi[u], cfg[u].mode, unit_inc[u]);
      end
   endgenerate

   // the split high byte is a plain timer: it ignores gate and counter-select,
   // and while it runs unit 1 can no longer raise overflow flag one
   assign hi0_inc = (cfg[0].mode == DTC_MODE_SPLIT) & run[1] & tick;
   assign res_hi0 = step(cnt_hi[0], 8'h00, DTC_MODE_SPLIT, hi0_inc);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_pre      = tick ? 4'h0 : pre + 4'h1;
      next_cnt_smp  = tick ? cnt_sync : cnt_smp;
      next_control  = control;
      next_mode_sel = mode_sel;
      next_lo       = cnt_lo;
      next_hi       = cnt_hi;
      next_ack      = req;
      next_dat      = 32'h0000_0000;

      // software access; hardware sets below take priority over clears
      if (wr) begin
         unique case (idx)
            IDX_CONTROL:   next_control  = wb_dat_i[7:0];
            IDX_MODE:      next_mode_sel = wb_dat_i[7:0];
            IDX_LOW_ZERO:  next_lo[0]    = wb_dat_i[7:0];
            IDX_HIGH_ZERO: next_hi[0]    = wb_dat_i[7:0];
            IDX_LOW_ONE:   next_lo[1]    = wb_dat_i[7:0];
            IDX_HIGH_ONE:  next_hi[1]    = wb_dat_i[7:0];
            default:       next_dat      = 32'h0000_0000;
         endcase
      end else if (req) begin
         unique case (idx)
            IDX_CONTROL:   next_dat = {24'h00_0000, control};
            IDX_MODE:      next_dat = {24'h00_0000, mode_sel};
            IDX_LOW_ZERO:  next_dat = {24'h00_0000, cnt_lo[0]};
            IDX_HIGH_ZERO: next_dat = {24'h00_0000, cnt_hi[0]};
            IDX_LOW_ONE:   next_dat = {24'h00_0000, cnt_lo[1]};
            IDX_HIGH_ONE:  next_dat = {24'h00_0000, cnt_hi[1]};
            default:       next_dat = 32'h0000_0000;
         endcase
      end

      // service clears
      if (ovf_served_i[0]) next_control[B_OVF_ZERO]  = 1'b0;
      if (ovf_served_i[1]) next_control[B_OVF_ONE]   = 1'b0;
      if (ext_served_i[0]) next_control[B_EDGE_ZERO] = 1'b0;
      if (ext_served_i[1]) next_control[B_EDGE_ONE]  = 1'b0;

      // a hardware count step beats a software write to the same byte
      if (unit_inc[0]) begin
         next_lo[0] = res[0].lo;
         if (moves_high(cfg[0].mode)) next_hi[0] = res[0].hi;
      end
      if (hi0_inc) begin
         next_hi[0] = res_hi0.lo;
      end
      if (unit_inc[1]) begin
         next_lo[1] = res[1].lo;
         if (moves_high(cfg[1].mode)) next_hi[1] = res[1].hi;
      end
      if (cfg[0].mode == DTC_MODE_13 && !unit_inc[0]) begin
         next_lo[0][7:5] = 3'h0;
      end
      if (cfg[1].mode == DTC_MODE_13 && !unit_inc[1]) begin
         next_lo[1][7:5] = 3'h0;
      end

      // hardware sets win over any clear in the same cycle
      if (res[0].ovf) next_control[B_OVF_ZERO] = 1'b1;
      if (cfg[0].mode == DTC_MODE_SPLIT) begin
         if (res_hi0.ovf) next_control[B_OVF_ONE] = 1'b1;
      end else if (res[1].ovf) begin
         next_control[B_OVF_ONE] = 1'b1;
      end
      if (pin_fall[0] && control[B_TYPE_ZERO]) begin
         next_control[B_EDGE_ZERO] = 1'b1;
      end
      if (pin_fall[1] && control[B_TYPE_ONE]) begin
         next_control[B_EDGE_ONE] = 1'b1;
      end

      // edge type raises the flag, level type asks while the pin is low
      next_ext_req[0] = next_control[B_TYPE_ZERO] ? next_control[B_EDGE_ZERO]
                                                  : ~pin_sync[0];
      next_ext_req[1] = next_control[B_TYPE_ONE]  ? next_control[B_EDGE_ONE]
                                                  : ~pin_sync[1];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control    <= RST_CONTROL;
         mode_sel   <= RST_MODE;
         cnt_lo[0]  <= RST_COUNT;
         cnt_lo[1]  <= RST_COUNT;
         cnt_hi[0]  <= RST_COUNT;
         cnt_hi[1]  <= RST_COUNT;
         pre        <= 4'h0;
         cnt_meta   <= 2'b11;
         cnt_sync   <= 2'b11;
         cnt_smp    <= 2'b11;
         pin_meta   <= 2'b11;
         pin_sync   <= 2'b11;
         pin_prev   <= 2'b11;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
         ovf_flag_o <= 2'b00;
         ext_req_o  <= 2'b00;
      end else begin
         control    <= next_control;
         mode_sel   <= next_mode_sel;
         cnt_lo     <= next_lo;
         cnt_hi     <= next_hi;
         pre        <= next_pre;
         cnt_meta   <= count_input_i;
         cnt_sync   <= cnt_meta;
         cnt_smp    <= next_cnt_smp;
         pin_meta   <= ext_pin_i;
         pin_sync   <= pin_meta;
         pin_prev   <= pin_sync;
         wb_ack_o   <= next_ack;
         wb_dat_o   <= next_dat;
         ovf_flag_o <= {next_control[B_OVF_ONE], next_control[B_OVF_ZERO]};
         ext_req_o  <= next_ext_req;
      end
   end

endmodule // dtc_timer

`default_nettype wire

// ==== rtl/dtc_pkg.sv ====
// dual timer/counter package: register map, field positions, modes, carriers
// assumes a 32-bit classic wishbone bus with word-aligned registers
package dtc_pkg;

   // ----------------------------------------------------------------
   // register word addresses (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam int unsigned ADR_W             = 6;
   localparam logic [5:0]  IDX_CONTROL       = 6'h00; // timer_control_status
   localparam logic [5:0]  IDX_MODE          = 6'h01; // timer_mode_select
   localparam logic [5:0]  IDX_LOW_ZERO      = 6'h02; // count_low_byte_zero
   localparam logic [5:0]  IDX_HIGH_ZERO     = 6'h03; // count_high_byte_zero
   localparam logic [5:0]  IDX_LOW_ONE       = 6'h04; // count_low_byte_one
   localparam logic [5:0]  IDX_HIGH_ONE      = 6'h05; // count_high_byte_one

   // ----------------------------------------------------------------
   // timer_control_status bit positions
   // ----------------------------------------------------------------
   localparam int unsigned B_OVF_ONE         = 7;
   localparam int unsigned B_RUN_ONE         = 6;
   localparam int unsigned B_OVF_ZERO        = 5;
   localparam int unsigned B_RUN_ZERO        = 4;
   localparam int unsigned B_EDGE_ONE        = 3;
   localparam int unsigned B_TYPE_ONE        = 2;
   localparam int unsigned B_EDGE_ZERO       = 1;
   localparam int unsigned B_TYPE_ZERO       = 0;

   // ----------------------------------------------------------------
   // timer_mode_select: upper nibble unit 1, lower nibble unit 0
   // ----------------------------------------------------------------
   localparam int unsigned MODE_NIB_ONE      = 4;
   localparam int unsigned MODE_NIB_ZERO     = 0;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_CONTROL       = 8'h00;
   localparam logic [7:0]  RST_MODE          = 8'h00;
   localparam logic [7:0]  RST_COUNT         = 8'h00;
   localparam int unsigned CLKS_PER_MACHINE  = 12;

   typedef enum logic [1:0] {
      DTC_MODE_13,
      DTC_MODE_16,
      DTC_MODE_RELOAD,
      DTC_MODE_SPLIT
   } dtc_mode_t;

   // one unit's nibble of timer_mode_select
   typedef struct packed {
      logic      gate;
      logic      ctr;
      dtc_mode_t mode;
   } dtc_unit_cfg_t;

   // result of one counting step on a byte pair
   typedef struct packed {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } dtc_step_t;

endpackage

// ==== tb/dtc_pin_model.sv ====
// pin-side partner: count inputs and interrupt/gate pins
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model (
   input  wire logic       clk_i,   // block clock
   output logic      [1:0] count_o, // count inputs, idle high
   output logic      [1:0] pin_o    // interrupt/gate pins, idle high
);
   initial begin
      count_o = 2'b11;
      pin_o   = 2'b11;
   end
   // ----------------------------------------------------------------
   // levels held two machine cycles: one fall per 48 clocks at most
   // ----------------------------------------------------------------
   task pulses(input int u, input int n);
      repeat (n) begin
         count_o[u] <= 1'b0;
         repeat (24) @(posedge clk_i);
         count_o[u] <= 1'b1;
         repeat (24) @(posedge clk_i);
      end
   endtask
   task set_pin(input int u, input logic v);
      pin_o[u] <= v;
      @(posedge clk_i);
   endtask
endmodule // dtc_pin_model
`default_nettype wire

// ==== tb/dtc_timer_sva.sv ====
// port assertions for the dual timer/counter
// assumes classic single-cycle bus masters and pulsed service strobes
`timescale 1ns/1ns
`default_nettype none
module dtc_timer_sva
   import dtc_pkg::*;
#(
   parameter int unsigned MACHINE_DIV = CLKS_PER_MACHINE
) (
   input wire logic             clk_i,         // clock
   input wire logic             rst_i,         // reset
   input wire logic             wb_cyc_i,      // cycle
   input wire logic             wb_stb_i,      // strobe
   input wire logic             wb_we_i,       // write
   input wire logic [ADR_W+1:0] wb_adr_i,      // address
   input wire logic [3:0]       wb_sel_i,      // lanes
   input wire logic [31:0]      wb_dat_i,      // write data
   input wire logic [31:0]      wb_dat_o,      // read data
   input wire logic             wb_ack_o,      // acknowledge
   input wire logic [1:0]       count_input_i, // count inputs
   input wire logic [1:0]       ext_pin_i,     // pins
   input wire logic [1:0]       ovf_served_i,  // overflow service
   input wire logic [1:0]       ext_served_i,  // pin service
   input wire logic [1:0]       ovf_flag_o,    // overflow flags
   input wire logic [1:0]       ext_req_o      // pin requests
);
   // ----------------------------------------------------------------
   // shadow of the trigger type bits, taken at the accepting edge
   // ----------------------------------------------------------------
   logic [1:0] typ;
   logic [1:0] next_typ;
   always_comb begin
      next_typ = typ;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i[ADR_W+1:2] == IDX_CONTROL) begin
         next_typ = {wb_dat_i[B_TYPE_ONE], wb_dat_i[B_TYPE_ZERO]};
      end
   end
   always_ff @(posedge clk_i) begin
      typ <= rst_i ? 2'b00 : next_typ;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside an answer");
   unmapped_zero_a: assert property (wb_ack_o && wb_adr_i[ADR_W+1:2] > IDX_HIGH_ONE
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   level_req_a: assert property ((!typ[1] && $stable(ext_pin_i[1]))[*4]
      |-> ext_req_o[1] == !ext_pin_i[1]) else $error("level request wrong");
   edge_flag_a: assert property (typ[0] && $fell(ext_pin_i[0])
      |-> ##[2:5] ext_req_o[0]) else $error("falling edge not flagged");
   edge_serve_a: assert property ((typ[0] && ext_pin_i[0])[*6] ##0 ext_served_i[0]
      |-> ##2 !ext_req_o[0]) else $error("edge flag not cleared by service");
   ovf_serve_a: assert property (ovf_served_i != 2'b00
      |-> ##2 (ovf_flag_o & $past(ovf_served_i, 2)) == 2'b00)
      else $error("overflow flag not cleared by service");
   cover property (wb_ack_o && !wb_we_i);
   cover property ($rose(ovf_flag_o[1]));
   cover property ($rose(ext_req_o[0]));
endmodule // dtc_timer_sva
bind dtc_timer dtc_timer_sva #(.MACHINE_DIV(MACHINE_DIV)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .count_input_i(count_input_i), .ext_pin_i(ext_pin_i), .ovf_served_i(ovf_served_i),
   .ext_served_i(ext_served_i), .ovf_flag_o(ovf_flag_o), .ext_req_o(ext_req_o));
`default_nettype wire

// ==== tb/tb_dual_timer_counter.sv ====
// self-checking bench: registers, timer modes, counting, pins
// assumes the pin model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_dual_timer_counter;
   import dtc_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [1:0]  cnt_in, pin, ovf_srv, ext_srv, ovf_flag, ext_req;
   logic [31:0] exp_q[$];
   logic [7:0]  d;
   int          fail_count, check_count, cycles, n;
   integer      seed;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   dtc_timer #(.MACHINE_DIV(12)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .count_input_i(cnt_in), .ext_pin_i(pin),
      .ovf_served_i(ovf_srv), .ext_served_i(ext_srv), .ovf_flag_o(ovf_flag),
      .ext_req_o(ext_req));
   dtc_pin_model i_pins (.clk_i(clk_i), .count_o(cnt_in), .pin_o(pin));
   // ----------------------------------------------------------------
   // checking, bus cycles, verdict
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      check_count++;
      if (got !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] v,
                      input logic [3:0] s);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      sel  <= s;
      wdat <= {24'h0, v};
      @(posedge clk_i);
      // no limit of its own: only the bench timeout ends a hung access
      while (ack !== 1'b1) begin
         @(posedge clk_i);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      bus(1'b1, idx, v, 4'hF);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, idx, 8'h00, 4'hF);
   endtask
   // the run window is a whole number of machine cycles, so prescaler phase drops out
   task automatic run_case(input logic [7:0] m, input int u, input logic [7:0] lo, hi, run,
                           input int k, input logic [7:0] elo, ehi, input logic [1:0] ef);
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_MODE, m);
      wr(IDX_LOW_ZERO, u ? 8'h00 : lo);
      wr(IDX_HIGH_ZERO, u ? 8'h00 : hi);
      wr(IDX_LOW_ONE, u ? lo : 8'h00);
      wr(IDX_HIGH_ONE, u ? hi : 8'h00);
      wr(IDX_CONTROL, run);
      repeat (12 * k - 3) @(posedge clk_i);
      chk("overflow flags", {30'h0, ovf_flag}, {30'h0, ef});
      wr(IDX_CONTROL, 8'h00);
      rd(IDX_LOW_ZERO, u ? 8'h00 : elo);
      rd(IDX_HIGH_ZERO, u ? 8'h00 : ehi);
      rd(IDX_LOW_ONE, u ? elo : 8'h00);
      rd(IDX_HIGH_ONE, u ? ehi : 8'h00);
      rd(IDX_CONTROL, 8'h00);
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() > 0) chk("read data", exp_q.pop_front(), rdat);
         else chk("unexpected read", 32'h0, 32'hFFFFFFFF);
      end
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      seed = 32'hbcb0277e;
      {rst_i, cyc, stb, we, adr, sel, wdat, ovf_srv, ext_srv} = '0;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 7; i++) rd(6'(i), 8'h00);
      d = 8'($random(seed));
      wr(IDX_MODE, d);
      bus(1'b1, IDX_MODE, ~d, 4'hE);
      wr(6'h07, 8'hFF);
      rd(6'h07, 8'h00);
      rd(IDX_MODE, d);
      run_case(8'h01, 0, 8'hFE, 8'hFF, 8'h10, 3, 8'h01, 8'h00, 2'b01);
      run_case(8'h00, 0, 8'hFF, 8'hFF, 8'h10, 2, 8'h01, 8'h00, 2'b01);
      run_case(8'h20, 1, 8'hFE, 8'hF0, 8'h40, 3, 8'hF1, 8'hF0, 2'b10);
      run_case(8'h33, 0, 8'hFE, 8'hFE, 8'h50, 3, 8'h01, 8'h01, 2'b11);
      run_case(8'h10, 1, 8'hFD, 8'hFF, 8'h40, 4, 8'h01, 8'h00, 2'b10);
      run_case(8'h02, 0, 8'hFE, 8'h80, 8'h10, 3, 8'h81, 8'h80, 2'b01);
      run_case(8'h00, 1, 8'hFF, 8'hFF, 8'h40, 2, 8'h01, 8'h00, 2'b10);
      wr(IDX_CONTROL, 8'hA0);
      chk("overflow flags", {30'h0, ovf_flag}, 32'h3);
      ovf_srv <= 2'b11;
      @(posedge clk_i);
      ovf_srv <= 2'b00;
      repeat (3) @(posedge clk_i);
      chk("overflow flags", {30'h0, ovf_flag}, 32'h0);
      for (int u = 0; u < 2; u++) begin
         wr(IDX_MODE, u ? 8'h50 : 8'h05);
         wr(u ? IDX_LOW_ONE : IDX_LOW_ZERO, 8'h00);
         wr(IDX_CONTROL, u ? 8'h40 : 8'h10);
         n = 1 + ($random(seed) & 3);
         i_pins.pulses(u, n);
         i_pins.set_pin(u, 1'b0);
         wr(IDX_MODE, u ? 8'hD0 : 8'h0D);
         i_pins.pulses(u, 3);
         i_pins.set_pin(u, 1'b1);
         i_pins.pulses(u, 2);
         repeat (30) @(posedge clk_i);
         wr(IDX_CONTROL, 8'h00);
         rd(u ? IDX_LOW_ONE : IDX_LOW_ZERO, 8'(n + 2));
      end
      for (int u = 0; u < 2; u++) begin
         wr(IDX_CONTROL, 8'h05);
         i_pins.set_pin(u, 1'b0);
         repeat (8) @(posedge clk_i);
         chk("pin requests", {30'h0, ext_req}, u ? 32'h2 : 32'h1);
         rd(IDX_CONTROL, u ? 8'h0D : 8'h07);
         i_pins.set_pin(u, 1'b1);
         repeat (8) @(posedge clk_i);
         ext_srv <= u ? 2'b10 : 2'b01;
         @(posedge clk_i);
         ext_srv <= 2'b00;
         repeat (4) @(posedge clk_i);
         chk("pin requests", {30'h0, ext_req}, 32'h0);
      end
      wr(IDX_CONTROL, 8'h00);
      i_pins.set_pin(1, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("pin requests", {30'h0, ext_req}, 32'h2);
      rd(IDX_CONTROL, 8'h00);
      i_pins.set_pin(1, 1'b1);
      repeat (8) @(posedge clk_i);
      complete_run();
   end
endmodule // tb_dual_timer_counter
`default_nettype wire
